//--- dual_core_irq_flag_mask_idle_bench.sv
module dual_core_irq_flag_mask_idle_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, kick = 0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [15:0] em = 16'h0000, be;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, m;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic interprocessor_raise_field, core_irq, clocks_off;
    logic [15:0] core_pending;
    logic [4:0] idx = 0;
    logic [17:0] src;
    logic [33:0] rq[$], bq[$];
    int n_errors = 0, n_compared = 0, seed = 32'h3cd2_9b12;
    int pos[17] = '{14, 13, 12, 11, 10, 7, 6, 11, 10, 7, 6, 5, 4, 9, 3, 1, 0};
    irq_flag_mask dut_u (.aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready(1'b1), .interprocessor_request(src[0]), .dma_ch5_request(src[1]),
        .dma_ch4_request(src[2]), .dma_ch3_request(src[3]), .dma_ch2_request(src[4]),
        .dma_ch1_request(src[5]), .dma_ch0_request(src[6]), .serial1_tx_request(src[7]),
        .serial1_rx_request(src[8]), .serial2_tx_request(src[9]), .serial2_rx_request(src[10]),
        .serial0_tx_request(src[11]), .serial0_rx_request(src[12]), .host_to_core_signal(src[13]),
        .timer_request(src[14]), .ext_pin1_request(src[15]), .ext_pin0_request(src[16]),
        .sibling_powerdown_req(src[17]), .interprocessor_raise_field, .core_irq, .core_pending,
        .clocks_off);
    irq_far_end far_u (.aclk, .kick, .idx, .src);
    always #12.5 aclk = ~aclk;
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        bq.push_back({32'h0, r});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    endtask
    task automatic rd(input logic [3:0] a, input logic [33:0] e);
        rq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    endtask
    task automatic kick_src(input int i);
        kick <= 1'b1;
        idx <= i[4:0];
        @(posedge aclk);
        kick <= 1'b0;
        repeat (9) @(posedge aclk);
    endtask
    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge aclk) begin
        if (s_axi_rvalid === 1'b1) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid === 1'b1) check({32'h0, s_axi_bresp}, bq.pop_front());
    end
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        stop_test();
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(4'h0, 34'h0);
        rd(4'h4, 34'h0);
        rd(4'h6, {2'b10, 32'h0});
        wr(4'h6, 32'hFFFF_FFFF, 2'b10);
        $display("test reset done");
        for (int i = 0; i < 17; i++) begin
            kick_src(i);
            check({33'h0, core_irq}, 34'h0);
            rd(4'h4, 34'h1 << pos[i]);
            wr(4'h4, 32'h1 << pos[i], 2'b00);
            rd(4'h4, 34'h0);
        end
        $display("test sources done");
        for (int i = 0; i < 4; i++) begin
            m = $random(seed);
            be = {{8{m[17]}}, {8{m[16]}}};
            em = (em & ~be) | (m[15:0] & be & 16'h7EFB);
            s_axi_wstrb <= {2'b00, m[17:16]};
            wr(4'h0, m, 2'b00);
            rd(4'h0, {18'h0, em});
        end
        s_axi_wstrb <= 4'hF;
        $display("test mask done");
        wr(4'h0, 32'h8, 2'b00);
        kick_src(14);
        check({17'h0, core_pending, core_irq}, {17'h0, 16'h0008, 1'b1});
        wr(4'h4, 32'h8, 2'b00);
        check({33'h0, core_irq}, 34'h0);
        $display("test irq done");
        for (int o = 0; o < 2; o++) begin
            if (o == 1) kick_src(17);
            else wr(4'h8, 32'h1, 2'b00);
            repeat (8) @(posedge aclk);
            check({33'h0, clocks_off}, 34'h0);
            if (o == 1) wr(4'h8, 32'h1, 2'b00);
            else kick_src(17);
            repeat (8) @(posedge aclk);
            check({33'h0, clocks_off}, 34'h1);
            kick_src(14);
            check({33'h0, clocks_off}, 34'h0);
            wr(4'h4, 32'h8, 2'b00);
        end
        $display("test powerdown done");
        wr(4'hC, 32'h1, 2'b00);
        check({33'h0, interprocessor_raise_field}, 34'h1);
        wr(4'hC, 32'h0, 2'b00);
        check({33'h0, interprocessor_raise_field}, 34'h0);
        $display("test raise done");
        stop_test();
    end
endmodule // dual_core_irq_flag_mask_idle_bench

//--- irq_cfg.svh
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH
// Register byte offsets
`define OFS_MASK 4'h0
`define OFS_FLAG 4'h4
`define OFS_PDN 4'h8
`define OFS_IPC 4'hC
// Bit positions
`define BIT_IPR 14
`define BIT_DMA5 13
`define BIT_DMA4 12
`define BIT_S1TX 11
`define BIT_S1RX 10
`define BIT_HOST 9
`define BIT_S2TX 7
`define BIT_S2RX 6
`define BIT_S0TX 5
`define BIT_S0RX 4
`define BIT_TMR 3
`define BIT_EXT1 1
`define BIT_EXT0 0
`define BIT_RSV15 15
`define BIT_RSV8 8
`define BIT_RSV2 2
// Request bit of the power-down and interprocessor control words
`define BIT_CTL_REQ 0
// Implemented source bits; 15, 8 and 2 are reserved and read zero
`define SRC_BITS 16'h7EFB
`define MASK_RST 16'h0000
`define FLAG_RST 16'h0000
`define RESP_OK 2'b00
`define RESP_ERR 2'b10
`endif

//--- irq_far_end.sv
module irq_far_end (
    input wire logic aclk,
    input wire logic kick,
    input wire logic [4:0] idx,
    output logic [17:0] src
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] cnt_ff = 3'h0;
    logic [4:0] cur_ff = 5'h0;
    always @(posedge aclk) begin
        if (kick) begin
            cur_ff <= idx;
            cnt_ff <= 3'h3;
        end else if (cnt_ff != 3'h0) begin
            cnt_ff <= cnt_ff - 3'h1;
        end
    end
    // Each request is raised, then dropped to 0 before another
    assign src = (cnt_ff != 3'h0) ? (18'h1 << cur_ff) : 18'h0;
endmodule // irq_far_end

//--- irq_flag_mask.sv
// Behaviour
// - Flag bit 1 means pending, 0 none; mask bit 1 enables, 0 masks.
// - Bit 14 holds the interprocessor request from the sibling subsystem.
// - Bit 13 is DMA channel 5, bit 12 DMA channel 4.
// - Bit 11 serial1 transmit or DMA3; bit 10 serial1 receive or DMA2.
// - Bit 9 is the host-port request from the host signal.
// - Bit 7 serial2 transmit or DMA1; bit 6 serial2 receive or DMA0.
// - Bit 4 serial0 receive; bit 5 serial0 transmit.
// - Bit 3 is the timer request.
// - Bit 1 external pin 1, bit 0 external pin 0.
// - Bits 15, 8 and 2 are reserved with no source.
// - Clock gating waits until both subsystems request deep power-down.
// - With both requesting, internal clocks stop without further software action.
// - Result independent of request order; each request held until the other.
// - Incoming interprocessor request latches into flag bit 14.
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`include "irq_cfg.svh"
module irq_flag_mask
    import irq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic interprocessor_request,
    input wire logic dma_ch5_request,
    input wire logic dma_ch4_request,
    input wire logic dma_ch3_request,
    input wire logic dma_ch2_request,
    input wire logic dma_ch1_request,
    input wire logic dma_ch0_request,
    input wire logic serial1_tx_request,
    input wire logic serial1_rx_request,
    input wire logic serial2_tx_request,
    input wire logic serial2_rx_request,
    input wire logic serial0_tx_request,
    input wire logic serial0_rx_request,
    input wire logic host_to_core_signal,
    input wire logic timer_request,
    input wire logic ext_pin1_request,
    input wire logic ext_pin0_request,
    input wire logic sibling_powerdown_req,
    output logic interprocessor_raise_field,
    output logic core_irq,
    output logic [15:0] core_pending,
    output logic clocks_off
);
    logic [15:0] mask_ff;
    logic [15:0] flag_ff;
    logic [15:0] nxt_mask;
    logic [15:0] nxt_flag;
    logic [15:0] src_raw;
    logic [15:0] src_now;
    logic [15:0] src_prev_ff;
    logic [15:0] src_rise;
    logic [1:0] ext_sync;
    logic ipr_ff;
    logic pdreq_ff;
    logic aw_ff;
    logic w_ff;
    logic [3:0] awaddr_ff;
    logic [15:0] wdata_ff;
    logic [1:0] wstrb_lo_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic pd_held;

    // Pin requests cross from outside the clock domain
    sync2 #(.W(2)) u_ext_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .din({ext_pin1_request, ext_pin0_request}),
        .dout(ext_sync)
    );

    // Source-to-bit map; shared bits OR both sources
    assign src_raw[`BIT_RSV15] = 1'b0;
    assign src_raw[`BIT_IPR] = interprocessor_request;
    assign src_raw[`BIT_DMA5] = dma_ch5_request;
    assign src_raw[`BIT_DMA4] = dma_ch4_request;
    assign src_raw[`BIT_S1TX] = serial1_tx_request | dma_ch3_request;
    assign src_raw[`BIT_S1RX] = serial1_rx_request | dma_ch2_request;
    assign src_raw[`BIT_HOST] = host_to_core_signal;
    assign src_raw[`BIT_RSV8] = 1'b0;
    assign src_raw[`BIT_S2TX] = serial2_tx_request | dma_ch1_request;
    assign src_raw[`BIT_S2RX] = serial2_rx_request | dma_ch0_request;
    assign src_raw[`BIT_S0TX] = serial0_tx_request;
    assign src_raw[`BIT_S0RX] = serial0_rx_request;
    assign src_raw[`BIT_TMR] = timer_request;
    assign src_raw[`BIT_RSV2] = 1'b0;
    assign src_raw[`BIT_EXT1] = ext_sync[1];
    assign src_raw[`BIT_EXT0] = ext_sync[0];
    assign src_now = src_raw & `SRC_BITS;
    // Rising edge of each source is one event
    assign src_rise = src_now & ~src_prev_ff;

    // AXI write decode
    wire wr_fire = aw_ff && w_ff && !bvalid_ff;
    wire wr_mask = wr_fire && (awaddr_ff == `OFS_MASK);
    wire wr_flag = wr_fire && (awaddr_ff == `OFS_FLAG);
    wire wr_pdn = wr_fire && (awaddr_ff == `OFS_PDN);
    wire wr_ipc = wr_fire && (awaddr_ff == `OFS_IPC);
    wire wr_ok = wr_mask || wr_flag || wr_pdn || wr_ipc;
    wire [15:0] wbyte_en = {{8{wstrb_lo_ff[1]}}, {8{wstrb_lo_ff[0]}}};
    wire [15:0] wbits = wdata_ff & wbyte_en;

    assign nxt_mask = wr_mask ? ((mask_ff & ~wbyte_en) | (wbits & `SRC_BITS)) : mask_ff;
    // Set wins over write-one-to-clear; mask does not gate setting
    assign nxt_flag = ((flag_ff & ~(wr_flag ? wbits : 16'h0000)) | src_rise) & `SRC_BITS;

    wire aw_take = s_axi_awvalid && !aw_ff;
    wire w_take = s_axi_wvalid && !w_ff;
    // No AW, W or AR handshake may complete while the clock enable freezes the state
    assign s_axi_awready = !aw_ff && ce;
    assign s_axi_wready = !w_ff && ce;
    assign s_axi_arready = !rvalid_ff && ce;
    wire ar_take = s_axi_arvalid && !rvalid_ff;

    wire [31:0] rd_mux =
        (s_axi_araddr == `OFS_MASK) ? {16'h0000, mask_ff} :
        (s_axi_araddr == `OFS_FLAG) ? {16'h0000, flag_ff} :
        (s_axi_araddr == `OFS_PDN) ? {30'h0000_0000, clocks_off, pd_held} :
        (s_axi_araddr == `OFS_IPC) ? {31'h0000_0000, ipr_ff} : 32'h0000_0000;
    wire rd_ok = (s_axi_araddr == `OFS_MASK) || (s_axi_araddr == `OFS_FLAG) ||
                 (s_axi_araddr == `OFS_PDN) || (s_axi_araddr == `OFS_IPC);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_ff <= `MASK_RST;
            flag_ff <= `FLAG_RST;
            src_prev_ff <= 16'h0000;
        end else if (ce) begin
            mask_ff <= nxt_mask;
            flag_ff <= nxt_flag;
            src_prev_ff <= src_now;
        end
    end

    // Control writes: interprocessor raise and power-down request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ipr_ff <= 1'b0;
            pdreq_ff <= 1'b0;
        end else if (ce) begin
            if (wr_ipc && wstrb_lo_ff[0]) ipr_ff <= wdata_ff[`BIT_CTL_REQ];
            pdreq_ff <= wr_pdn && wstrb_lo_ff[0] && wdata_ff[`BIT_CTL_REQ];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 4'h0;
            wdata_ff <= 16'h0000;
            wstrb_lo_ff <= 2'b00;
            bvalid_ff <= 1'b0;
            bresp_ff <= `RESP_OK;
        end else if (ce) begin
            if (aw_take) begin
                aw_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                w_ff <= 1'b1;
                wdata_ff <= s_axi_wdata[15:0];
                wstrb_lo_ff <= s_axi_wstrb[1:0];
            end
            if (wr_fire) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_ok ? `RESP_OK : `RESP_ERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `RESP_OK;
        end else if (ce) begin
            if (ar_take) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_mux;
                rresp_ff <= rd_ok ? `RESP_OK : `RESP_ERR;
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // Any masked-in pending flag wakes the subsystem from power-down
    pdn_coord u_pdn (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .local_req(pdreq_ff),
        .sibling_req(sibling_powerdown_req),
        .wake(core_irq),
        .clocks_off(clocks_off),
        .local_held(pd_held)
    );

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign interprocessor_raise_field = ipr_ff;
    assign core_pending = flag_ff & mask_ff;
    assign core_irq = |(flag_ff & mask_ff);
endmodule // irq_flag_mask

//--- irq_flag_mask_properties.sv
module irq_flag_mask_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic sibling_powerdown_req,
    input wire logic core_irq,
    input wire logic [15:0] core_pending,
    input wire logic clocks_off
);
    timeunit 1ns;
    timeprecision 100ps;
    logic sib_seen_ff, loc_seen_ff;
    wire w_fire = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire pdn_fire = w_fire && s_axi_awaddr == 4'h8 && s_axi_wdata[0];
    // Requests seen since the last wake-up
    always_ff @(posedge aclk) begin
        if (!aresetn || core_irq) begin
            sib_seen_ff <= 1'b0;
            loc_seen_ff <= 1'b0;
        end else begin
            sib_seen_ff <= sib_seen_ff | sibling_powerdown_req;
            loc_seen_ff <= loc_seen_ff | pdn_fire;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_irq_level: assert property (
        core_irq == (core_pending != 16'h0000)) else $error("core_irq disagrees with pending");
    chk_rsvd_pending: assert property (
        (core_pending & 16'h8104) == 16'h0000) else $error("reserved bit pending");
    chk_gate_both: assert property (
        $rose(clocks_off) |-> sib_seen_ff && loc_seen_ff) else $error("clocks gated too early");
    chk_gate_follows: assert property (
        (pdn_fire && sib_seen_ff) || (sibling_powerdown_req && loc_seen_ff)
        |-> ##[1:8] (clocks_off || core_irq)) else $error("clocks not gated");
    chk_wake_exit: assert property (
        clocks_off && core_irq |-> ##[1:3] !clocks_off) else $error("no wake on irq");
    chk_b_after: assert property (
        w_fire |-> ##2 s_axi_bvalid) else $error("write response late");
    chk_r_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000)
        else $error("read answer wrong");
    chk_ar_block: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
endmodule // irq_flag_mask_properties
bind irq_flag_mask irq_flag_mask_properties chk_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .sibling_powerdown_req, .core_irq, .core_pending,
    .clocks_off);

//--- irq_pkg.sv
package irq_pkg;
    typedef enum logic [1:0] {
        PD_RUN = 2'b00,
        PD_WAIT = 2'b01,
        PD_GATED = 2'b10
    } pdn_state_t;
endpackage

//--- pdn_coord.sv
`include "irq_cfg.svh"
module pdn_coord
    import irq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic local_req,
    input wire logic sibling_req,
    input wire logic wake,
    output logic clocks_off,
    output logic local_held
);
    pdn_state_t state_ff;
    pdn_state_t nxt_state;
    logic sib_ff;
    logic nxt_sib;
    // Each side's request is held until both have arrived, order free
    assign nxt_sib = wake ? 1'b0 : (sib_ff | sibling_req);
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            PD_RUN: if (local_req && !wake) nxt_state = PD_WAIT;
            PD_WAIT: begin
                if (wake) nxt_state = PD_RUN;
                else if (sib_ff || sibling_req) nxt_state = PD_GATED;
            end
            PD_GATED: if (wake) nxt_state = PD_RUN;
            default: nxt_state = PD_RUN;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= PD_RUN;
            sib_ff <= 1'b0;
        end else if (ce) begin
            state_ff <= nxt_state;
            sib_ff <= nxt_sib;
        end
    end
    assign clocks_off = (state_ff == PD_GATED);
    assign local_held = (state_ff != PD_RUN);
endmodule // pdn_coord

//--- sync2.sv
module sync2 #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] hold_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= '0;
            hold_ff <= '0;
        end else if (ce) begin
            meta_ff <= din;
            hold_ff <= meta_ff;
        end
    end
    assign dout = hold_ff;
endmodule // sync2
